// ==== src/ddsl_top.sv ====
`timescale 1ns/1ps
module ddsl_top
    import ddsl_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Serial pins from the host
    input wire logic serial_clk,
    input wire logic select_n,
    input wire logic serial_in,
    input wire logic load_strobe_a_n,
    input wire logic load_strobe_b_n,
    input wire logic preset_n,
    input wire logic preset_level,
    input wire logic sleep_n,
    // Converter codes and power state
    output logic [WORD_W-1:0] chan_a_code,
    output logic [WORD_W-1:0] chan_b_code,
    output logic converter_awake
);

    // Idle levels: strobes, preset and sleep inactive, deselected
    localparam ddsl_pins_s PINS_IDLE = '{sck: 1'b0, sel_n: 1'b1, serial_in: 1'b0, load_strobe_a_n: 1'b1,
                                         load_strobe_b_n: 1'b1, preset_n: 1'b1, preset_hi: 1'b0,
                                         sleep_n: 1'b1};

    ddsl_pins_s pins_raw;
    ddsl_pins_s pins;
    logic sck_prev_q;
    logic sck_rise;
    logic [WORD_W-1:0] shift_q;
    logic [WORD_W-1:0] hold_a_q;
    logic [WORD_W-1:0] hold_b_q;
    logic [WORD_W-1:0] load_val;
    logic [WORD_W-1:0] preset_val;
    logic narrow_q;
    logic aw_full_q;
    logic w_full_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_fire;
    logic wr_hit;
    logic [31:0] rd_word;
    logic rd_hit;

    // Gather pins into the carrier
    always_comb begin
        pins_raw = '{sck: serial_clk, sel_n: select_n, serial_in: serial_in,
                     load_strobe_a_n: load_strobe_a_n, load_strobe_b_n: load_strobe_b_n,
                     preset_n: preset_n, preset_hi: preset_level, sleep_n: sleep_n};
    end

    // Clock and data share one synchroniser so they stay aligned
    ddsl_sync #(
        .WIDTH(PIN_COUNT),
        .RST_VAL(PINS_IDLE)
    ) u_pin_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(pins_raw),
        .sync_out(pins)
    );

    // Serial clock edge detect on the synchronised level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sck_prev_q <= 1'b0;
        end else begin
            sck_prev_q <= pins.sck;
        end
    end

    assign sck_rise = pins.sck & ~sck_prev_q;

    // Shift register; sleep does not stop it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shift_q <= HOLD_RST;
        end else if (sck_rise && !pins.sel_n) begin
            shift_q <= {shift_q[WORD_W-2:0], pins.serial_in};
        end
    end

    // Narrow mode keeps only the low ten bits of a load
    always_comb begin
        load_val = narrow_q ? (shift_q & NARROW_MASK) : shift_q;
        preset_val = pins.preset_hi ? PRESET_HALF : PRESET_ZERO;
    end

    // Channel A holding register: preset first, then transparent load
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_a_q <= HOLD_RST;
        end else if (!pins.preset_n) begin
            hold_a_q <= preset_val;
        end else if (!pins.load_strobe_a_n) begin
            hold_a_q <= load_val;
        end
    end

    // Channel B holding register, same shape as A
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_b_q <= HOLD_RST;
        end else if (!pins.preset_n) begin
            hold_b_q <= preset_val;
        end else if (!pins.load_strobe_b_n) begin
            hold_b_q <= load_val;
        end
    end

    // Codes freeze while asleep; the registers themselves keep going
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chan_a_code <= HOLD_RST;
            chan_b_code <= HOLD_RST;
            converter_awake <= 1'b1;
        end else begin
            converter_awake <= pins.sleep_n;
            if (pins.sleep_n) begin
                chan_a_code <= hold_a_q;
                chan_b_code <= hold_b_q;
            end
        end
    end

    // Write address channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            awaddr_q <= 8'h00;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (wr_fire) begin
            aw_full_q <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    // Write data channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (wr_fire) begin
            w_full_q <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    // Write commits once both halves are held
    assign wr_fire = aw_full_q & w_full_q & ~s_axi_bvalid;
    assign wr_hit = (awaddr_q[7:2] == OFS_CTRL[7:2]);

    // Control register; only the low byte lane carries a field
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            narrow_q <= CTRL_NARROW_RST;
        end else if (wr_fire && wr_hit && wstrb_q[0]) begin
            narrow_q <= wdata_q[CTRL_NARROW_BIT];
        end
    end

    // Write response; read-only or unmapped words answer SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read decode
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr[7:2])
            OFS_CTRL[7:2]: rd_word = {31'h0000_0000, narrow_q};
            OFS_STATUS[7:2]: rd_word = {24'h00_0000, pins};
            OFS_SHIFT[7:2]: rd_word = {20'h0_0000, shift_q};
            OFS_HOLD_A[7:2]: rd_word = {20'h0_0000, hold_a_q};
            OFS_HOLD_B[7:2]: rd_word = {20'h0_0000, hold_b_q};
            default: rd_hit = 1'b0;
        endcase
    end

    // Read channel: one read in flight, answer next cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Checks on the synchronised view of the pins and on the AXI channels
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_asleep;
        !pins.sleep_n;
    endsequence

    sequence s_wake;
        s_asleep ##1 pins.sleep_n;
    endsequence

    sequence s_shift_edge;
        sck_rise && !pins.sel_n;
    endsequence

    chk_shift_deselect_hold: assert property (
        pins.sel_n |=> $stable(shift_q)
    ) else $error("shift register moved while deselected");

    chk_shift_msb_first: assert property (
        (sck_rise && !pins.sel_n) |=> shift_q == {$past(shift_q[WORD_W-2:0]), $past(pins.serial_in)}
    ) else $error("shift did not take serial bit at the bottom");

    chk_load_a_transparent: assert property (
        (!pins.load_strobe_a_n && pins.preset_n && !narrow_q) |=> hold_a_q == $past(shift_q)
    ) else $error("channel A did not follow shift register");

    chk_load_b_transparent: assert property (
        (!pins.load_strobe_b_n && pins.preset_n && !narrow_q) |=> hold_b_q == $past(shift_q)
    ) else $error("channel B did not follow shift register");

    chk_latch_hold_a: assert property (
        (pins.load_strobe_a_n && pins.preset_n) |=> $stable(hold_a_q)
    ) else $error("channel A changed while latched");

    chk_preset_half_scale: assert property (
        (!pins.preset_n && pins.preset_hi) |=> (hold_a_q == PRESET_HALF) && (hold_b_q == PRESET_HALF)
    ) else $error("preset did not give half scale");

    chk_preset_zero_scale: assert property (
        (!pins.preset_n && !pins.preset_hi && !pins.load_strobe_a_n) |=> hold_a_q == PRESET_ZERO
    ) else $error("preset lost to strobe or not zero");

    chk_sleep_freeze: assert property (
        s_asleep |=> $stable(chan_a_code) && $stable(chan_b_code) && !converter_awake
    ) else $error("codes moved while asleep");

    chk_wake_latest: assert property (
        s_wake |=> (chan_a_code == $past(hold_a_q)) && (chan_b_code == $past(hold_b_q))
    ) else $error("wake did not show latest holding value");

    chk_read_answer: assert property (
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid ##0 !s_axi_arready
    ) else $error("read answer not one cycle after address");

    chk_latch_hold_b: assert property (
        (pins.load_strobe_b_n && pins.preset_n) |=> $stable(hold_b_q)
    ) else $error("channel B changed while latched");

    chk_strobe_ignores_select: assert property (
        (pins.sel_n && !pins.load_strobe_a_n && pins.preset_n && !narrow_q) |=> hold_a_q == $past(shift_q)
    ) else $error("deselect blocked a strobe load");

    chk_sleep_shift: assert property (
        (s_asleep ##0 s_shift_edge) |=> shift_q == {$past(shift_q[WORD_W-2:0]), $past(pins.serial_in)}
    ) else $error("shift stalled while asleep");

    chk_narrow_load_a: assert property (
        (!pins.load_strobe_a_n && pins.preset_n && narrow_q) |=> hold_a_q == ($past(shift_q) & NARROW_MASK)
    ) else $error("narrow load kept top bits");

    chk_preset_zero_both: assert property (
        (!pins.preset_n && !pins.preset_hi) |=> (hold_a_q == PRESET_ZERO) && (hold_b_q == PRESET_ZERO)
    ) else $error("preset did not clear both channels");

    chk_preset_wins_b: assert property (
        (!pins.preset_n && !pins.load_strobe_b_n) |=> hold_b_q == $past(preset_val)
    ) else $error("strobe B beat preset");

    chk_awake_codes_follow: assert property (
        pins.sleep_n |=> converter_awake && (chan_a_code == $past(hold_a_q)) && (chan_b_code == $past(hold_b_q))
    ) else $error("awake codes lag holding registers");

    chk_idle_shift_hold: assert property (
        !sck_rise |=> $stable(shift_q)
    ) else $error("shift register moved without a clock edge");

    chk_sleep_keeps_a: assert property (
        (s_asleep ##0 (pins.load_strobe_a_n && pins.preset_n)) |=> $stable(hold_a_q)
    ) else $error("sleep disturbed channel A");

    chk_write_answer: assert property (
        wr_fire |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready
    ) else $error("write answer missing after commit");

    chk_write_refused: assert property (
        (wr_fire && !wr_hit) |=> (s_axi_bresp == RESP_SLVERR) && $stable(narrow_q)
    ) else $error("refused write changed state");

    chk_read_unmapped: assert property (
        (s_axi_arvalid && s_axi_arready && !rd_hit) |=> (s_axi_rresp == RESP_SLVERR) && (s_axi_rdata == 32'h0000_0000)
    ) else $error("unmapped read not refused");

    chk_read_release: assert property (
        (s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid && s_axi_arready
    ) else $error("read channel not released after answer");

endmodule

// ==== src/ddsl_pkg.sv ====
package ddsl_pkg;

    // Word layout
    localparam int WORD_W = 12;
    localparam int NARROW_W = 10;
    localparam logic [WORD_W-1:0] PRESET_HALF = 12'h800;
    localparam logic [WORD_W-1:0] PRESET_ZERO = 12'h000;
    localparam logic [WORD_W-1:0] NARROW_MASK = 12'h3FF;

    // Synchroniser depth and pin count
    localparam int SYNC_STAGES = 2;
    localparam int PIN_COUNT = 8;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_SHIFT = 8'h08;
    localparam logic [7:0] OFS_HOLD_A = 8'h0C;
    localparam logic [7:0] OFS_HOLD_B = 8'h10;

    // Field positions
    localparam int CTRL_NARROW_BIT = 0;

    // Reset values
    localparam logic CTRL_NARROW_RST = 1'b0;
    localparam logic [WORD_W-1:0] HOLD_RST = 12'h000;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Pin levels as one carrier, lowest field last
    typedef struct packed {
        logic sck;
        logic sel_n;
        logic serial_in;
        logic load_strobe_a_n;
        logic load_strobe_b_n;
        logic preset_n;
        logic preset_hi;
        logic sleep_n;
    } ddsl_pins_s;

endpackage

// ==== src/ddsl_sync.sv ====
`timescale 1ns/1ps
// Two-flop synchroniser for a vector of independent levels
module ddsl_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // First stage read only by the second stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// ==== dv/ddsl_host.sv ====
`timescale 1ns/1ps
// Host driving the serial pins; link clock idles low between frames
module ddsl_host (
    // Bench clock
    input wire logic aclk,
    // Serial pins
    output logic serial_clk,
    output logic select_n,
    output logic serial_in
);
    initial begin
        serial_clk = 1'b0;
        select_n = 1'b1;
        serial_in = 1'b0;
    end

    // One twelve-bit frame, 80 ns link period; sel high selects the device
    task automatic send(input logic [11:0] w, input logic sel);
        @(posedge aclk);
        select_n <= ~sel;
        for (int i = 11; i >= 0; i--) begin
            serial_in <= w[i];
            repeat (4) @(posedge aclk);
            serial_clk <= 1'b1;
            repeat (4) @(posedge aclk);
            serial_clk <= 1'b0;
        end
        repeat (4) @(posedge aclk);
        select_n <= 1'b1;
        // Released data line shows the inverse so stale bits never look valid
        serial_in <= ~w[0];
    endtask
endmodule

// ==== dv/test_dual_dac_serial_load.sv ====
`timescale 1ns/1ps
module test_dual_dac_serial_load;
    import ddsl_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, converter_awake;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic serial_clk, select_n, serial_in;
    logic strobe_a_n = 1'b1, strobe_b_n = 1'b1, preset_n = 1'b1, preset_level = 1'b0, sleep_n = 1'b1;
    logic [WORD_W-1:0] chan_a_code, chan_b_code;
    int errors = 0;
    int checks_done = 0;
    // Reference model of shift, holding and output codes
    logic [11:0] shift_m = 12'h000, ha = 12'h000, hb = 12'h000, ca = 12'h000, cb = 12'h000, msk = 12'hFFF;
    logic awake = 1'b1;

    always #5 aclk = ~aclk;

    ddsl_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .serial_clk(serial_clk),
        .select_n(select_n), .serial_in(serial_in), .load_strobe_a_n(strobe_a_n), .load_strobe_b_n(strobe_b_n),
        .preset_n(preset_n), .preset_level(preset_level), .sleep_n(sleep_n), .chan_a_code(chan_a_code),
        .chan_b_code(chan_b_code), .converter_awake(converter_awake));

    ddsl_host host (.aclk(aclk), .serial_clk(serial_clk), .select_n(select_n), .serial_in(serial_in));

    task automatic complete_run;
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Write: address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            n++;
        end while (bvalid !== 1'b1 && n < 50);
        bready <= 1'b0;
        if (n >= 50) errors++;
        chk({30'h0, bresp}, {30'h0, r});
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            n++;
        end while (rvalid !== 1'b1 && n < 50);
        rready <= 1'b0;
        if (n >= 50) errors++;
        chk(rdata, e);
        chk({30'h0, rresp}, {30'h0, r});
    endtask

    // Codes follow holding only while awake; asleep they stay frozen
    task automatic check_all;
        if (awake) begin
            ca = ha;
            cb = hb;
        end
        rd_chk(OFS_SHIFT, {20'h0, shift_m}, RESP_OKAY);
        rd_chk(OFS_HOLD_A, {20'h0, ha}, RESP_OKAY);
        rd_chk(OFS_HOLD_B, {20'h0, hb}, RESP_OKAY);
        chk({20'h0, chan_a_code}, {20'h0, ca});
        chk({20'h0, chan_b_code}, {20'h0, cb});
        chk({31'h0, converter_awake}, {31'h0, awake});
    endtask

    // Strobe pulse with the link idle, so no bit moves while a strobe is low
    task automatic load(input logic ch);
        @(posedge aclk);
        if (ch) strobe_b_n <= 1'b0;
        else strobe_a_n <= 1'b0;
        repeat (6) @(posedge aclk);
        strobe_a_n <= 1'b1;
        strobe_b_n <= 1'b1;
        repeat (6) @(posedge aclk);
        if (ch) hb = shift_m & msk;
        else ha = shift_m & msk;
    endtask

    initial begin
        logic [11:0] w;
        void'($urandom(32'hEFA64AF0));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(OFS_CTRL, 32'h0, RESP_OKAY);
        // Idle pins as seen through the synchroniser
        rd_chk(OFS_STATUS, 32'h0000_005D, RESP_OKAY);
        check_all;
        // Random words into both channels, select high during strobes
        for (int k = 0; k < 4; k++) begin
            w = 12'($urandom);
            host.send(w, 1'b1);
            shift_m = w;
            load(k[0]);
            check_all;
        end
        w = 12'($urandom);
        host.send(w, 1'b1);
        shift_m = w;
        check_all;
        host.send(~w, 1'b0);
        check_all;
        // Preset and both strobes released together: preset must win
        for (int lv = 0; lv < 2; lv++) begin
            @(posedge aclk);
            preset_level <= lv[0];
            strobe_a_n <= 1'b0;
            strobe_b_n <= 1'b0;
            preset_n <= 1'b0;
            repeat (6) @(posedge aclk);
            strobe_a_n <= 1'b1;
            strobe_b_n <= 1'b1;
            preset_n <= 1'b1;
            repeat (6) @(posedge aclk);
            ha = lv[0] ? PRESET_HALF : PRESET_ZERO;
            hb = ha;
            check_all;
        end
        // Sleep keeps contents, still loads, wake shows the latest
        sleep_n <= 1'b0;
        awake = 1'b0;
        w = 12'($urandom);
        host.send(w, 1'b1);
        shift_m = w;
        load(1'b1);
        check_all;
        sleep_n <= 1'b1;
        awake = 1'b1;
        repeat (6) @(posedge aclk);
        check_all;
        // Ten-bit mode masks the top bits of a load
        axi_wr(OFS_CTRL, 32'h1, RESP_OKAY);
        rd_chk(OFS_CTRL, 32'h1, RESP_OKAY);
        msk = NARROW_MASK;
        host.send(12'hFFF, 1'b1);
        shift_m = 12'hFFF;
        load(1'b0);
        check_all;
        axi_wr(OFS_CTRL, 32'h0, RESP_OKAY);
        msk = 12'hFFF;
        // Only the low byte lane reaches the mode bit
        wstrb <= 4'hE;
        axi_wr(OFS_CTRL, 32'h1, RESP_OKAY);
        rd_chk(OFS_CTRL, 32'h0, RESP_OKAY);
        wstrb <= 4'hF;
        // Unmapped and read-only places refuse
        axi_wr(8'h14, 32'h1, RESP_SLVERR);
        rd_chk(8'h14, 32'h0, RESP_SLVERR);
        axi_wr(OFS_HOLD_A, 32'h5, RESP_SLVERR);
        check_all;
        complete_run;
    end

    // Run needs some 1100 cycles; the margin is generous
    initial begin
        #200us;
        errors++;
        complete_run;
    end
endmodule
